//--- rtl/irq_unit_pkg.sv
// constants for the interrupt mask and priority unit
package irq_unit_pkg;
  localparam logic [7:0]  ENABLE_ADDR   = 8'ha8;
  localparam logic [7:0]  LEVEL_ADDR    = 8'hb8;
  localparam logic [7:0]  ENABLE_RESET  = 8'h00;
  localparam logic [7:0]  LEVEL_RESET   = 8'h80;
  localparam logic [7:0]  LEVEL_RO_MASK = 8'h80;
  localparam int          GATE_BIT      = 7;
  localparam int          SPI_BIT       = 6;
  localparam int          TIMER2_BIT    = 5;
  localparam int          UART0_BIT     = 4;
  localparam int          TIMER1_BIT    = 3;
  localparam int          EXT1_BIT      = 2;
  localparam int          TIMER0_BIT    = 1;
  localparam int          EXT0_BIT      = 0;
  localparam int          NUM_BASIC     = 7;
  localparam int          NUM_SRC       = 23;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STEP      = 16'h0008;
  localparam logic [4:0]  FIRST_EXT_IDX = 5'h07;
endpackage

//--- rtl/interrupt_mask_priority_unit.sv
// interrupt enable, level select and vectored request arbitration
// Operation
// - sources 18..22 get vectors 0x93..0xb3, eight apart, order 18..22
// - global gate bit 7 at zero blocks every source
// - with gate set, a source passes only if its own mask is set
// - enable bit 6 gates the spi request
// - enable bit 5 gates timer2, raised by low or high overflow flag
// - enable bit 4 gates the first uart request
// - enable bit 3 gates timer1 overflow, bit 1 gates timer0 overflow
// - enable bit 2 gates external request pin b
// - enable bit 0 gates external request pin a
// - level bits 6..0 set high or low level for the seven basic sources
// - level register bit 7 reads one, writes to it ignored
// - enable register at 0xa8, bit addressable, on every page
// - level register at 0xb8, bit addressable, on every page
// - high preempts low, high never preempted, ties by fixed order
// - requests sampled and decoded every cycle, one detect cycle
// - pending after return runs one more instruction before re-entry
module interrupt_mask_priority_unit (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata_r,
  input  wire logic        bit_wr,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_wdata,
  input  wire logic        ext0_pend,
  input  wire logic        timer0_overflow_flag,
  input  wire logic        ext1_pend,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        uart0_pend,
  input  wire logic        timer2_low_overflow_flag,
  input  wire logic        timer2_high_overflow_flag,
  input  wire logic        spi_pend,
  input  wire logic [22:7] ext_pend,
  input  wire logic [22:7] ext_mask,
  input  wire logic [22:7] ext_level,
  input  wire logic        irq_ack,
  input  wire logic        return_from_isr_instr_done,
  input  wire logic        instr_done,
  output logic             irq_req_r,
  output logic      [4:0]  irq_index_r,
  output logic      [15:0] irq_vector_r,
  output logic             irq_level_r
);

  logic [7:0]  global_and_basic_source_enable_r;
  logic [7:0]  basic_source_level_select_r;
  logic        act_low_r;
  logic        act_high_r;
  logic        holdoff_r;
  logic [22:0] pend_all;
  logic [22:0] mask_all;
  logic [22:0] lvl_all;
  logic [22:0] en_vec;
  logic [4:0]  hi_idx;
  logic [4:0]  lo_idx;
  logic        hi_any;
  logic        lo_any;
  logic        blocked;
  logic        cand_valid;
  logic [4:0]  win_idx;
  logic        win_lvl;
  logic        enable_addr_hit;
  logic        level_addr_hit;
  logic        enable_bit_hit;
  logic        level_bit_hit;

  assign enable_addr_hit = sfr_addr == irq_unit_pkg::ENABLE_ADDR;
  assign enable_bit_hit  = bit_addr[7:3] == irq_unit_pkg::ENABLE_ADDR[7:3];
  assign level_addr_hit = sfr_addr == irq_unit_pkg::LEVEL_ADDR;
  assign level_bit_hit  = bit_addr[7:3] == irq_unit_pkg::LEVEL_ADDR[7:3];

  // no page input: both registers answer whatever page is selected
  // enable reset value
  always_ff @(posedge core_clk) begin
    if (rst) begin
      global_and_basic_source_enable_r <= irq_unit_pkg::ENABLE_RESET;
    end else if (sfr_wr && enable_addr_hit) begin
      global_and_basic_source_enable_r <= sfr_wdata;
    end else if (bit_wr && enable_bit_hit) begin
      global_and_basic_source_enable_r[bit_addr[2:0]] <= bit_wdata;
    end
  end

  // top level bit held at one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      basic_source_level_select_r <= irq_unit_pkg::LEVEL_RESET;
    end else if (sfr_wr && level_addr_hit) begin
      basic_source_level_select_r <= sfr_wdata | irq_unit_pkg::LEVEL_RO_MASK;
    end else if (bit_wr && level_bit_hit && (bit_addr[2:0] != 3'h7)) begin
      basic_source_level_select_r[bit_addr[2:0]] <= bit_wdata;
    end
  end

  // other sfr addresses read as zero so the core can or the read buses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd && enable_addr_hit) begin
      sfr_rdata_r <= global_and_basic_source_enable_r;
    end else if (sfr_rd && level_addr_hit) begin
      sfr_rdata_r <= basic_source_level_select_r;
    end else if (sfr_rd) begin
      sfr_rdata_r <= 8'h00;
    end
  end

  assign pend_all[irq_unit_pkg::EXT0_BIT]   = ext0_pend;
  assign pend_all[irq_unit_pkg::TIMER0_BIT] = timer0_overflow_flag;
  assign pend_all[irq_unit_pkg::TIMER1_BIT] = timer1_overflow_flag;
  assign pend_all[irq_unit_pkg::EXT1_BIT]   = ext1_pend;
  assign pend_all[irq_unit_pkg::UART0_BIT]  = uart0_pend;
  assign pend_all[irq_unit_pkg::TIMER2_BIT] = timer2_low_overflow_flag | timer2_high_overflow_flag;
  assign pend_all[irq_unit_pkg::SPI_BIT]    = spi_pend;
  assign pend_all[22:7] = ext_pend;
  assign mask_all = {ext_mask, global_and_basic_source_enable_r[6:0]};
  assign lvl_all  = {ext_level, basic_source_level_select_r[6:0]};

  // per source mask under global gate
  for (genvar i = 0; i < irq_unit_pkg::NUM_SRC; i++) begin : g_src
    assign en_vec[i] = global_and_basic_source_enable_r[irq_unit_pkg::GATE_BIT] & mask_all[i] & pend_all[i];
  end

  always_comb begin
    hi_idx = 5'h00;
    lo_idx = 5'h00;
    hi_any = 1'b0;
    lo_any = 1'b0;
    for (int i = irq_unit_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (en_vec[i] && lvl_all[i]) begin
        hi_idx = 5'(i);
        hi_any = 1'b1;
      end
      if (en_vec[i] && !lvl_all[i]) begin
        lo_idx = 5'(i);
        lo_any = 1'b1;
      end
    end
  end

  // hold off across return and the next instruction
  assign blocked = holdoff_r | return_from_isr_instr_done | irq_ack;

  always_comb begin
    cand_valid = 1'b0;
    win_idx    = 5'h00;
    win_lvl    = 1'b0;
    if (!blocked && !act_high_r) begin
      if (hi_any) begin
        cand_valid = 1'b1;
        win_idx    = hi_idx;
        win_lvl    = 1'b1;
      end else if (lo_any && !act_low_r) begin
        cand_valid = 1'b1;
        win_idx    = lo_idx;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_req_r   <= 1'b0;
      irq_index_r <= 5'h00;
      irq_level_r <= 1'b0;
    end else begin
      irq_req_r   <= cand_valid;
      irq_index_r <= win_idx;
      irq_level_r <= win_lvl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_vector_r <= irq_unit_pkg::VEC_BASE;
    end else begin
      irq_vector_r <= irq_unit_pkg::VEC_BASE + irq_unit_pkg::VEC_STEP * {11'h000, win_idx};
    end
  end

  // nesting state: a return retires the high routine first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_low_r  <= 1'b0;
      act_high_r <= 1'b0;
    end else if (irq_ack && irq_req_r) begin
      if (irq_level_r) begin
        act_high_r <= 1'b1;
      end else begin
        act_low_r <= 1'b1;
      end
    end else if (return_from_isr_instr_done) begin
      if (act_high_r) begin
        act_high_r <= 1'b0;
      end else begin
        act_low_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdoff_r <= 1'b0;
    end else if (return_from_isr_instr_done) begin
      holdoff_r <= 1'b1;
    end else if (instr_done) begin
      holdoff_r <= 1'b0;
    end
  end

  gate_block_a: assert property (@(posedge core_clk) disable iff (rst)
    !global_and_basic_source_enable_r[irq_unit_pkg::GATE_BIT] |=> !irq_req_r)
    else $error("request with global gate clear");

  vector_map_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_req_r |-> irq_vector_r == 16'h0003 + 16'h0008 * {11'h000, irq_index_r})
    else $error("vector does not match source index");

  mask_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    (global_and_basic_source_enable_r[7] && (en_vec != 23'h0) && !blocked && !act_high_r && !act_low_r)
      |=> irq_req_r)
    else $error("enabled pending source not forwarded");

  spi_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r == 5'h06) |-> $past(global_and_basic_source_enable_r[6] && spi_pend))
    else $error("spi request without its mask");

  timer2_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r == 5'h05) |->
      $past(global_and_basic_source_enable_r[5] && (timer2_low_overflow_flag || timer2_high_overflow_flag)))
    else $error("timer2 request without mask or flag");

  uart0_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r == 5'h04) |-> $past(global_and_basic_source_enable_r[4]))
    else $error("uart request without its mask");

  timer_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_req_r && (irq_index_r == 5'h03 || irq_index_r == 5'h01) |->
      (irq_index_r == 5'h03) ? $past(global_and_basic_source_enable_r[3])
                             : $past(global_and_basic_source_enable_r[1]))
    else $error("timer request without its mask");

  ext_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r == 5'h02) |-> $past(global_and_basic_source_enable_r[2] && ext1_pend))
    else $error("pin b request without its mask");

  ext0_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r == 5'h00) |-> $past(global_and_basic_source_enable_r[0] && ext0_pend))
    else $error("pin a request without its mask");

  level_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    (irq_req_r && irq_index_r < 5'h07) |->
      ((($past(basic_source_level_select_r) >> irq_index_r) & 8'h01) == {7'h00, irq_level_r}))
    else $error("level does not follow level register");

  top_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    (sfr_rd && level_addr_hit) |=> sfr_rdata_r[7])
    else $error("level register bit 7 read as zero");

  level_top_a: assert property (@(posedge core_clk) disable iff (rst)
    basic_source_level_select_r[7])
    else $error("level register bit 7 cleared");

  enable_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (sfr_wr && enable_addr_hit) |=> global_and_basic_source_enable_r == $past(sfr_wdata))
    else $error("enable register byte write lost");

  level_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (sfr_wr && level_addr_hit) |=> basic_source_level_select_r == ($past(sfr_wdata) | 8'h80))
    else $error("level register byte write lost");

  reset_val_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> (global_and_basic_source_enable_r == 8'h00 && basic_source_level_select_r == 8'h80
      && !irq_req_r))
    else $error("wrong values after reset");

  no_preempt_a: assert property (@(posedge core_clk) disable iff (rst)
    act_high_r |=> !irq_req_r)
    else $error("request while high routine runs");

  high_first_a: assert property (@(posedge core_clk) disable iff (rst)
    (cand_valid && hi_any) |=> irq_level_r)
    else $error("low request won over high");

  one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
    cand_valid |=> (irq_req_r && irq_index_r == $past(win_idx)))
    else $error("request not presented next cycle");

  return_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (return_from_isr_instr_done && !instr_done) |=> !irq_req_r ##1 (!irq_req_r || $past(instr_done)))
    else $error("re-entry before one more instruction");

endmodule // interrupt_mask_priority_unit

//--- test/core_model.sv
// core side model: takes requests, returns from routines
module core_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic irq_req_r,
  input  wire logic slow,
  input  wire logic ret_go,
  output logic      irq_ack,
  output logic      return_from_isr_instr_done,
  output logic      instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sh_r;
  logic       seen_r;
  // one ack per request; when slow the request must stand a cycle longer
  always_ff @(posedge core_clk) begin
    seen_r  <= irq_req_r & ~irq_ack;
    irq_ack <= ~rst & irq_req_r & ~irq_ack & (~slow | seen_r);
    sh_r    <= rst ? 4'h0 : {sh_r[2:0], ret_go};
  end
  // the instruction after a return ends three cycles later
  assign return_from_isr_instr_done = sh_r[0];
  assign instr_done = sh_r[3];
endmodule // core_model

//--- test/tb.sv
// self-checking bench for the interrupt mask and priority unit
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, sfr_wr, sfr_rd, bit_wr, bit_wdata, t2h, slow, ret_go;
  logic        irq_ack, return_from_isr_instr_done, instr_done, irq_req_r, irq_level_r;
  logic        rd_seen = 1'b0;
  logic [7:0]  sfr_addr, sfr_wdata, bit_addr, sfr_rdata_r, lvl;
  logic [23:0] irq_exp;
  logic [22:0] pv;
  logic [22:7] em, el;
  logic [4:0]  irq_index_r;
  logic [15:0] irq_vector_r;
  logic [23:0] rd_q[$];
  logic [23:0] irq_q[$];
  int          fail_count = 0;
  int          comparisons = 0;
  int          n;

  interrupt_mask_priority_unit dut_u (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata_r, .bit_wr, .bit_addr, .bit_wdata, .ext0_pend(pv[0]), .timer0_overflow_flag(pv[1]),
    .ext1_pend(pv[2]), .timer1_overflow_flag(pv[3]), .uart0_pend(pv[4]),
    .timer2_low_overflow_flag(pv[5] & ~t2h), .timer2_high_overflow_flag(pv[5] & t2h),
    .spi_pend(pv[6]), .ext_pend(pv[22:7]), .ext_mask(em), .ext_level(el), .irq_ack,
    .return_from_isr_instr_done, .instr_done, .irq_req_r, .irq_index_r, .irq_vector_r, .irq_level_r);
  core_model core_u (.core_clk, .rst, .irq_req_r, .slow, .ret_go, .irq_ack, .return_from_isr_instr_done,
    .instr_done);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string s, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", s, exp, seen);
      fail_count++;
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a gap cycle after each strobe so it is never raised twice in one step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask
  task automatic bw(logic [7:0] a, logic d);
    bit_addr = a;
    bit_wdata = d;
    bit_wr = 1'b1;
    tick;
    bit_wr = 1'b0;
    tick;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rd_q.push_back({16'h0000, e});
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    tick;
  endtask
  function automatic logic [23:0] ex(int k, logic l);
    return {2'b00, l, 5'(k), 16'h0003 + 16'(8 * k)};
  endfunction
  // first tick skips an ack that is still up from the previous wait
  task automatic waitack;
    n = 0;
    tick;
    while (irq_ack !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    chk("ack", {23'h0, irq_ack}, 24'h1);
  endtask
  task automatic retire;
    ret_go = 1'b1;
    tick;
    ret_go = 1'b0;
    repeat (6) tick;
  endtask
  task automatic svc(int k, logic l);
    irq_q.push_back(ex(k, l));
    slow = 1'($urandom);
    pv[k] = 1'b1;
    waitack;
    pv = '0;
    retire;
  endtask

  // results are compared in order as the outputs show them
  always @(posedge core_clk) begin
    rd_seen <= sfr_rd;
    if (rd_seen) chk("rdata", {16'h0000, sfr_rdata_r}, rd_q.pop_front());
    if (irq_ack) begin
      irq_exp = (irq_q.size() > 0) ? irq_q.pop_front() : 24'hffffff;
      chk("irq", {2'b00, irq_level_r, irq_index_r, irq_vector_r}, irq_exp);
    end
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    test_done;
  end

  initial begin
    {sfr_wr, sfr_rd, bit_wr, bit_wdata, t2h, slow, ret_go} = '0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    bit_addr = 8'h00;
    pv = '0;
    em = '0;
    el = '0;
    rst = 1'b1;
    n = $urandom(32'h0ff982d6);
    repeat (2) tick;
    rst = 1'b0;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80);
    rd(8'h55, 8'h00);
    lvl = 8'($urandom);
    wr(8'hb8, lvl & 8'h7f);
    bw(8'hbf, 1'b0);
    rd(8'hb8, lvl | 8'h80);
    lvl[4] = ~lvl[4];
    bw(8'hbc, lvl[4]);
    rd(8'hb8, lvl | 8'h80);
    for (int k = 0; k < 7; k++) begin
      wr(8'ha8, 8'h80 | (8'h01 << k));
      t2h = 1'($urandom);
      pv[6:0] = ~(7'h01 << k);
      svc(k, lvl[k]);
    end
    el = 16'($urandom);
    for (int k = 18; k < 23; k++) begin
      em = 16'h0001 << (k - 7);
      svc(k, el[k]);
    end
    em = '1;
    bw(8'haf, 1'b0);
    rd(8'ha8, 8'h40);
    pv = '1;
    repeat (6) tick;
    pv = '0;
    em = '0;
    wr(8'hb8, 8'h40);
    wr(8'ha8, 8'hff);
    irq_q.push_back(ex(1, 1'b0));
    pv[3:0] = 4'ha;
    waitack;
    pv[1] = 1'b0;
    irq_q.push_back(ex(6, 1'b1));
    pv[6] = 1'b1;
    waitack;
    pv[6] = 1'b0;
    retire;
    irq_q.push_back(ex(3, 1'b0));
    ret_go = 1'b1;
    tick;
    ret_go = 1'b0;
    repeat (5) begin
      chk("holdoff", {23'h0, irq_req_r}, 24'h0);
      tick;
    end
    chk("reentry", {23'h0, irq_req_r}, 24'h1);
    waitack;
    pv = '0;
    retire;
    chk("left", 24'(irq_q.size()), 24'h0);
    test_done;
  end
endmodule // tb
